/* hdl/swmon_defines.svh */
`ifndef SWMON_DEFINES_SVH
`define SWMON_DEFINES_SVH

// System clock rate, used to turn times into cycle counts.
`define SWM_CLK_MHZ          200

// Serial word length and the bit counter that tracks it.
`define SWM_WORD_BITS        16
`define SWM_BITCNT_W         5

// Command word reset value: no input masked, inputs 0 and 1 direct, scan off.
`define SWM_CMD_RESET        16'h0000

// Field positions of the command word.
`define SWM_CMD_MASK_LSB     0
`define SWM_CMD_WETTING_DIRECT_SELECT_BIT     8
`define SWM_CMD_SCAN_BIT     9

// Field positions of the status word.
`define SWM_STS_SWITCH_LSB   0
`define SWM_STS_ALERT_BIT    8

// Times as printed, in their own units.
`define SWM_DEB_TIME_MS      120
`define SWM_SCAN_PULSE_US    250
`define SWM_SCAN_PERIOD_MS   8
`define SWM_WD1_TIME_MS      84
`define SWM_RST_TIME_MS      21
`define SWM_REG_START_MS     1

// Cycle counts derived from the times and the clock rate.
`define SWM_DEB_CYCLES       (`SWM_DEB_TIME_MS * 1000 * `SWM_CLK_MHZ)
`define SWM_SCAN_ON_CYCLES   (`SWM_SCAN_PULSE_US * `SWM_CLK_MHZ)
`define SWM_SCAN_PER_CYCLES  (`SWM_SCAN_PERIOD_MS * 1000 * `SWM_CLK_MHZ)
`define SWM_WD1_CYCLES       (`SWM_WD1_TIME_MS * 1000 * `SWM_CLK_MHZ)
`define SWM_WD2_CYCLES       (2 * `SWM_WD1_CYCLES)
`define SWM_RST_CYCLES       (`SWM_RST_TIME_MS * 1000 * `SWM_CLK_MHZ)
`define SWM_REG_CYCLES       (`SWM_REG_START_MS * 1000 * `SWM_CLK_MHZ)

`endif

/* hdl/swmon_pkg.sv */
package swmon_pkg;

  // Operating modes of the monitor.
  typedef enum logic [1:0] {
    mode_normal,
    mode_scan,
    mode_shutdown
  } mode_t;

  // Watchdog supervisor states.
  typedef enum logic [1:0] {
    wd_run,
    wd_warn,
    wd_pulse
  } wd_state_t;

  // Command word as received over the serial port.
  typedef struct packed {
    logic [5:0] spare;
    logic       scan_enable;
    logic       wetting_direct_select;
    logic [7:0] mask;
  } command_t;

  // Status word as shifted out over the serial port.
  typedef struct packed {
    logic [6:0] zero;
    logic       alert;
    logic [7:0] switch_state;
  } status_t;

endpackage : swmon_pkg

/* hdl/switch_monitor_control_port.sv */
`timescale 1ns/1ps
`include "swmon_defines.svh"

// Contract
// - Shutdown input low forces shutdown mode and regulator off; high means normal or scanning, as the command word selects.
// - Master holds chip select low for a whole transfer; shifting only then.
// - Received word is committed on the rising edge of chip select.
// - Serial output changes on each rising serial clock edge while selected.
// - Serial output is not driven while chip select is high.
// - Serial input is sampled on each falling serial clock edge while selected.
// - Supervisor reset is driven low while the regulator output is undervoltage.
// - Supervisor reset is also driven low when the watchdog expires.
// - Every kick transition, either direction, restarts the watchdog timer, except during the reset pulse.
// - With wetting/direct select 0, inputs 0 and 1 appear on the direct outputs.
// - Eight inputs are debounced; a settled change raises the change alert.
// - A per-input mask stops that input from raising the change alert.
// - One shared debounce timer serves all eight inputs.
// - Normal mode keeps sense resistors connected on all inputs except direct channels 0 and 1.
// - Scanning mode connects sense resistors for a pulse each period and while a change is pending.
// - Shutdown mode releases all inputs and turns the regulator off.
// - Raising the change alert wakes the regulator when wired to regulator-on.
// - A serial read releases the change alert line.
// - Regulator output is declared usable only 1 ms after enabling.
// - Watchdog: alert after first timeout, reset pulse after second, alert release when the reset pulse ends.
module switch_monitor_control_port #(
  parameter int unsigned DEB_CYCLES      = `SWM_DEB_CYCLES,
  parameter int unsigned SCAN_ON_CYCLES  = `SWM_SCAN_ON_CYCLES,
  parameter int unsigned SCAN_PER_CYCLES = `SWM_SCAN_PER_CYCLES,
  parameter int unsigned WD1_CYCLES      = `SWM_WD1_CYCLES,
  parameter int unsigned WD2_CYCLES      = `SWM_WD2_CYCLES,
  parameter int unsigned RST_CYCLES      = `SWM_RST_CYCLES,
  parameter int unsigned REG_CYCLES      = `SWM_REG_CYCLES
) (
  // System clock and reset.
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  // Serial host port.
  input  wire logic       i_spi_clk,
  input  wire logic       i_cs_n,
  input  wire logic       i_sdi,
  output logic            o_sdo,
  output logic            o_sdo_oe,
  // Switch inputs and their front end.
  input  wire logic [7:0] i_switch_input,
  output logic [7:0]      o_sense_enable,
  output logic            o_direct_output_0,
  output logic            o_direct_output_1,
  // Change alert, open drain: pulls low while the enable is high.
  output logic            o_change_alert,
  output logic            o_change_alert_oe,
  // Regulator control.
  input  wire logic       i_shutdown_n,
  input  wire logic       i_regulator_on_n,
  input  wire logic       i_regulator_hold_n,
  output logic            o_regulator_enable,
  output logic            o_regulator_ready,
  // Supervisor, open drain reset pulls low while the enable is high.
  input  wire logic       i_watchdog_kick,
  input  wire logic       i_undervoltage_sense,
  output logic            o_supervisor_reset,
  output logic            o_supervisor_reset_oe
);

  // Serial clock domain state.
  logic                      rx_active;
  logic [`SWM_BITCNT_W-1:0]  bit_count;
  logic [`SWM_WORD_BITS-1:0] rx_shift;
  logic                      tx_loaded;
  logic [`SWM_WORD_BITS-1:0] tx_shift;

  // Synchronisers: first stage, second stage.
  logic [13:0] sync_a;
  logic [13:0] sync_b;
  logic        cs_prev;
  logic        kick_prev;

  // System domain state.
  swmon_pkg::command_t    command;
  swmon_pkg::status_t     status_snap;
  swmon_pkg::mode_t       mode;
  swmon_pkg::wd_state_t   wd_state;
  logic [7:0]             switch_state;
  logic [7:0]             last_raw;
  logic [31:0]            deb_count;
  logic [31:0]            scan_count;
  logic [31:0]            wd_count;
  logic [31:0]            reg_count;
  logic                   alert_pending;

  // Decoded synchronised pins.
  logic [7:0] sw_sync;
  logic       cs_n_sync;
  logic       shutdown_n_sync;
  logic       regulator_on_n_n_sync;
  logic       hold_n_sync;
  logic       kick_sync;
  logic       uv_sync;
  logic       commit;
  logic       kick_edge;
  logic       sensing;
  logic       change_event;
  logic [7:0] alert_candidates;
  logic       wd_warn_set;
  logic       wd_release;

  // Falling serial clock marks the frame active; chip select high clears it at once.
  always_ff @(negedge i_spi_clk or posedge i_cs_n) begin
    if (i_cs_n) begin
      rx_active <= 1'b0;
    end else begin
      rx_active <= 1'b1;
    end
  end

  // Data is sampled on the falling edge; the count restarts with each frame.
  always_ff @(negedge i_spi_clk) begin
    rx_shift <= {rx_shift[`SWM_WORD_BITS-2:0], i_sdi};
    if (!rx_active) begin
      bit_count <= `SWM_BITCNT_W'(1);
    end else if (bit_count != {`SWM_BITCNT_W{1'b1}}) begin
      bit_count <= bit_count + `SWM_BITCNT_W'(1);
    end
  end

  // The output driver turns off asynchronously as soon as chip select rises.
  always_ff @(posedge i_spi_clk or posedge i_cs_n) begin
    if (i_cs_n) begin
      o_sdo_oe  <= 1'b0;
      tx_loaded <= 1'b0;
    end else begin
      o_sdo_oe  <= 1'b1;
      tx_loaded <= 1'b1;
    end
  end

  // Status bits leave on rising edges, most significant first.
  // The snapshot is frozen by the system side while chip select is low.
  always_ff @(posedge i_spi_clk) begin
    if (!tx_loaded) begin
      o_sdo    <= status_snap[`SWM_WORD_BITS-1];
      tx_shift <= {status_snap[`SWM_WORD_BITS-2:0], 1'b0};
    end else begin
      o_sdo    <= tx_shift[`SWM_WORD_BITS-1];
      tx_shift <= {tx_shift[`SWM_WORD_BITS-2:0], 1'b0};
    end
  end

  // Two-stage synchronisers for every pin the system clock reads.
  always_ff @(posedge i_clk) begin
    sync_a <= {i_undervoltage_sense, i_watchdog_kick, i_regulator_hold_n,
               i_regulator_on_n, i_shutdown_n, i_cs_n, i_switch_input};
    sync_b <= sync_a;
  end

  assign sw_sync         = sync_b[7:0];
  assign cs_n_sync       = sync_b[8];
  assign shutdown_n_sync = sync_b[9];
  assign regulator_on_n_n_sync    = sync_b[10];
  assign hold_n_sync     = sync_b[11];
  assign kick_sync       = sync_b[12];
  assign uv_sync         = sync_b[13];

  // Edge history for chip select and watchdog kick, taken from the second stage.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      cs_prev   <= 1'b1;
      kick_prev <= 1'b0;
    end else begin
      cs_prev   <= cs_n_sync;
      kick_prev <= kick_sync;
    end
  end

  // A short frame is dropped so a glitch cannot corrupt the command word.
  assign commit    = cs_n_sync && !cs_prev && bit_count == `SWM_BITCNT_W'(`SWM_WORD_BITS);
  assign kick_edge = kick_sync != kick_prev;

  // Command word is taken only when chip select has returned high.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      command <= `SWM_CMD_RESET;
    end else if (commit) begin
      command <= rx_shift;
    end
  end

  // Status snapshot follows live state only while the port is idle.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      status_snap <= '0;
    end else if (cs_n_sync) begin
      status_snap              <= '0;
      status_snap.switch_state <= switch_state;
      status_snap.alert        <= alert_pending;
    end
  end

  // Mode selection: the shutdown pin overrides everything.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      mode <= swmon_pkg::mode_normal;
    end else if (!shutdown_n_sync) begin
      mode <= swmon_pkg::mode_shutdown;
    end else if (command.scan_enable) begin
      mode <= swmon_pkg::mode_scan;
    end else begin
      mode <= swmon_pkg::mode_normal;
    end
  end

  // Scan period counter, held at zero outside scanning.
  always_ff @(posedge i_clk) begin
    if (i_reset || mode != swmon_pkg::mode_scan) begin
      scan_count <= '0;
    end else if (scan_count >= 32'(SCAN_PER_CYCLES - 1)) begin
      scan_count <= '0;
    end else begin
      scan_count <= scan_count + 32'd1;
    end
  end

  // A pending change keeps sensing on in scan mode until it settles or bounces back.
  always_comb begin
    case (mode)
      swmon_pkg::mode_normal:   sensing = 1'b1;
      swmon_pkg::mode_scan:     sensing = scan_count < 32'(SCAN_ON_CYCLES) ||
                                          last_raw != switch_state;
      swmon_pkg::mode_shutdown: sensing = 1'b0;
      default:                  sensing = 1'b0;
    endcase
  end

  // Sense resistors per input; direct channels lose theirs.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_sense_enable <= 8'h00;
    end else begin
      o_sense_enable <= {8{sensing}} &
                        {6'h3f, {2{command.wetting_direct_select}}};
    end
  end

  // Level-shifted copies of inputs 0 and 1 in direct mode.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_direct_output_0 <= 1'b0;
      o_direct_output_1 <= 1'b0;
    end else begin
      o_direct_output_0 <= !command.wetting_direct_select && sw_sync[0];
      o_direct_output_1 <= !command.wetting_direct_select && sw_sync[1];
    end
  end

  // One debounce timer for the whole vector; any new movement restarts it.
  // This trades per-channel timing for a single counter.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      last_raw  <= 8'h00;
      deb_count <= '0;
    end else if (sensing) begin
      last_raw <= sw_sync;
      if (sw_sync != last_raw || sw_sync == switch_state || change_event) begin
        deb_count <= '0;
      end else begin
        deb_count <= deb_count + 32'd1;
      end
    end
  end

  assign change_event     = sensing && sw_sync == last_raw && sw_sync != switch_state &&
                            deb_count >= 32'(DEB_CYCLES - 1);
  assign alert_candidates = (sw_sync ^ switch_state) & ~command.mask &
                            {6'h3f, {2{command.wetting_direct_select}}};

  // Settled state of the inputs; direct channels are not reported.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      switch_state <= 8'h00;
    end else if (change_event) begin
      switch_state <= sw_sync & {6'h3f, {2{command.wetting_direct_select}}};
    end
  end

  // Alert flag: a new cause in the same cycle as a read wins over the release.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      alert_pending <= 1'b0;
    end else if ((change_event && alert_candidates != 8'h00) || wd_warn_set) begin
      alert_pending <= 1'b1;
    end else if (commit || wd_release) begin
      alert_pending <= 1'b0;
    end
  end

  assign o_change_alert    = 1'b0;
  assign o_change_alert_oe = alert_pending;

  // Regulator follows its two control inputs and the shutdown pin.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_regulator_enable <= 1'b0;
    end else begin
      o_regulator_enable <= shutdown_n_sync && (!regulator_on_n_n_sync || hold_n_sync);
    end
  end

  // Start-up delay before the regulator output counts as usable.
  always_ff @(posedge i_clk) begin
    if (i_reset || !o_regulator_enable) begin
      reg_count         <= '0;
      o_regulator_ready <= 1'b0;
    end else if (reg_count >= 32'(REG_CYCLES - 1)) begin
      o_regulator_ready <= 1'b1;
    end else begin
      reg_count <= reg_count + 32'd1;
    end
  end

  // Watchdog only supervises a powered host; kicks are ignored during the reset pulse.
  always_ff @(posedge i_clk) begin
    if (i_reset || !o_regulator_ready) begin
      wd_state <= swmon_pkg::wd_run;
      wd_count <= '0;
    end else begin
      case (wd_state)
        swmon_pkg::wd_run, swmon_pkg::wd_warn: begin
          if (kick_edge) begin
            wd_count <= '0;
            wd_state <= swmon_pkg::wd_run;
          end else if (wd_count >= 32'(WD2_CYCLES - 1)) begin
            wd_count <= '0;
            wd_state <= swmon_pkg::wd_pulse;
          end else begin
            wd_count <= wd_count + 32'd1;
            if (wd_count == 32'(WD1_CYCLES - 1)) begin
              wd_state <= swmon_pkg::wd_warn;
            end
          end
        end
        swmon_pkg::wd_pulse: begin
          if (wd_count >= 32'(RST_CYCLES - 1)) begin
            wd_count <= '0;
            wd_state <= swmon_pkg::wd_run;
          end else begin
            wd_count <= wd_count + 32'd1;
          end
        end
        default: begin
          wd_count <= '0;
          wd_state <= swmon_pkg::wd_run;
        end
      endcase
    end
  end

  assign wd_warn_set = o_regulator_ready && !kick_edge &&
                       wd_state == swmon_pkg::wd_run && wd_count == 32'(WD1_CYCLES - 1);
  assign wd_release  = o_regulator_ready && wd_state == swmon_pkg::wd_pulse &&
                       wd_count >= 32'(RST_CYCLES - 1);

  // Supervisor reset combines undervoltage and the watchdog pulse.
  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      o_supervisor_reset_oe <= 1'b0;
    end else begin
      o_supervisor_reset_oe <= uv_sync || (o_regulator_ready &&
                               wd_state == swmon_pkg::wd_pulse);
    end
  end

  assign o_supervisor_reset = 1'b0;

  // Checks on the behaviour above.
  sequence s_wd_silent;
    wd_state == swmon_pkg::wd_warn && !kick_edge && o_regulator_ready &&
      wd_count == 32'(WD2_CYCLES - 1);
  endsequence

  sequence s_wd_pulse_start;
    wd_state == swmon_pkg::wd_pulse ##1 o_supervisor_reset_oe;
  endsequence

  property p_shutdown_off;
    @(posedge i_clk) disable iff (i_reset)
    !shutdown_n_sync |=> !o_regulator_enable && mode == swmon_pkg::mode_shutdown;
  endproperty
  a_shutdown_off: assert property (p_shutdown_off) else $error("regulator on in shutdown");

  property p_shutdown_inputs;
    @(posedge i_clk) disable iff (i_reset)
    mode == swmon_pkg::mode_shutdown |=> o_sense_enable == 8'h00;
  endproperty
  a_shutdown_inputs: assert property (p_shutdown_inputs) else $error("inputs sensed in shutdown");

  property p_commit;
    @(posedge i_clk) disable iff (i_reset)
    commit |=> command == $past(rx_shift);
  endproperty
  a_commit: assert property (p_commit) else $error("command word not taken at select rise");

  property p_read_release;
    @(posedge i_clk) disable iff (i_reset)
    commit && !change_event && !wd_warn_set |=> !o_change_alert_oe;
  endproperty
  a_read_release: assert property (p_read_release) else $error("alert kept after read");

  property p_mask;
    @(posedge i_clk) disable iff (i_reset)
    change_event && ((sw_sync ^ switch_state) & ~command.mask) == 8'h00 &&
      !alert_pending && !wd_warn_set |=> !alert_pending;
  endproperty
  a_mask: assert property (p_mask) else $error("masked input raised alert");

  property p_regulator_on;
    @(posedge i_clk) disable iff (i_reset)
    shutdown_n_sync && !regulator_on_n_n_sync |=> o_regulator_enable;
  endproperty
  a_regulator_on: assert property (p_regulator_on) else $error("regulator not enabled");

  property p_ready_delay;
    @(posedge i_clk) disable iff (i_reset)
    $rose(o_regulator_enable) |-> !o_regulator_ready [*8];
  endproperty
  a_ready_delay: assert property (p_ready_delay) else $error("regulator ready too early");

  property p_kick_restart;
    @(posedge i_clk) disable iff (i_reset)
    kick_edge && o_regulator_ready && wd_state != swmon_pkg::wd_pulse |=> wd_count == 32'd0;
  endproperty
  a_kick_restart: assert property (p_kick_restart) else $error("kick did not restart timer");

  property p_wd_expire;
    @(posedge i_clk) disable iff (i_reset)
    s_wd_silent |=> s_wd_pulse_start;
  endproperty
  a_wd_expire: assert property (p_wd_expire) else $error("watchdog expiry gave no reset");

  property p_undervoltage;
    @(posedge i_clk) disable iff (i_reset)
    uv_sync |=> o_supervisor_reset_oe;
  endproperty
  a_undervoltage: assert property (p_undervoltage) else $error("no reset on undervoltage");

  property p_direct;
    @(posedge i_clk) disable iff (i_reset)
    !command.wetting_direct_select |=> o_direct_output_1 == $past(sw_sync[1]);
  endproperty
  a_direct: assert property (p_direct) else $error("direct output mismatch");

  property p_sdo_idle;
    @(posedge i_clk) disable iff (i_reset)
    i_cs_n |-> !o_sdo_oe;
  endproperty
  a_sdo_idle: assert property (p_sdo_idle) else $error("serial output driven while idle");

endmodule : switch_monitor_control_port

/* verif/swmon_host_model.sv */
`timescale 1ns/1ps
// Serial master of the host; its clock moves only inside frames, period 6 ns.
module swmon_host_model (
  // Serial lines toward the monitor.
  output logic      o_spi_clk,
  output logic      o_cs_n,
  output logic      o_sdi,
  input  wire logic i_sdo,
  input  wire logic i_sdo_oe
);
  // Idle: clock low, select high, data line at its pulldown level.
  initial begin
    o_spi_clk = 1'b0;
    o_cs_n    = 1'b1;
    o_sdi     = 1'b0;
  end

  // Shifts n bits MSB first and leaves select low, so the caller can look before the commit.
  task automatic shift(input logic [15:0] word, input int n, output logic [15:0] rd,
                       output logic oe_ok);
    rd        = 16'h0000;
    oe_ok     = 1'b1;
    o_cs_n    = 1'b0;
    #15;
    for (int i = 0; i < n; i++) begin
      o_spi_clk = 1'b1;
      o_sdi     = word[15-i];
      #3;
      o_spi_clk = 1'b0;
      rd        = {rd[14:0], i_sdo};
      oe_ok     = oe_ok & i_sdo_oe;
      #3;
    end
  endtask : shift

  // Releases select and waits out the commit; the gap also covers the minimum spacing.
  task automatic close;
    #4;
    o_cs_n = 1'b1;
    o_sdi  = 1'b0;
    #40;
  endtask : close
endmodule : swmon_host_model

/* verif/switch_monitor_control_port_tb_top.sv */
`timescale 1ns/1ps
module switch_monitor_control_port_tb_top;
  localparam int DEB = 20;
  localparam int SON = 5;
  localparam int SPER = 40;
  localparam int WD1 = 100;
  localparam int WD2 = 200;
  localparam int RST = 30;
  localparam int REG = 16;
  logic        i_clk, i_reset, spi_clk, cs_n, sdi, sdo, sdo_oe, kick, uv;
  logic        sd_n, on_n, hold_n, do0, do1, alert, alert_oe, reg_en, reg_rdy;
  logic        srst, srst_oe, kick_run, oe_ok;
  logic [7:0]  sw, sense;
  logic [15:0] rd;
  int          mismatches, checked, n;
  // Rows: shutdown_n, regulator_on_n, regulator_hold_n, expected enable.
  logic [3:0]  rows [8] = '{4'h9, 4'hb, 4'hc, 4'hf, 4'h0, 4'h2, 4'h4, 4'h6};

  switch_monitor_control_port #(.DEB_CYCLES(DEB), .SCAN_ON_CYCLES(SON),
    .SCAN_PER_CYCLES(SPER), .WD1_CYCLES(WD1), .WD2_CYCLES(WD2), .RST_CYCLES(RST),
    .REG_CYCLES(REG)) u_switch_monitor_control_port (
    .i_clk(i_clk), .i_reset(i_reset), .i_spi_clk(spi_clk), .i_cs_n(cs_n), .i_sdi(sdi),
    .o_sdo(sdo), .o_sdo_oe(sdo_oe), .i_switch_input(sw), .o_sense_enable(sense),
    .o_direct_output_0(do0), .o_direct_output_1(do1), .o_change_alert(alert),
    .o_change_alert_oe(alert_oe), .i_shutdown_n(sd_n), .i_regulator_on_n(on_n),
    .i_regulator_hold_n(hold_n), .o_regulator_enable(reg_en), .o_regulator_ready(reg_rdy),
    .i_watchdog_kick(kick), .i_undervoltage_sense(uv), .o_supervisor_reset(srst),
    .o_supervisor_reset_oe(srst_oe));

  swmon_host_model u_swmon_host_model (.o_spi_clk(spi_clk), .o_cs_n(cs_n), .o_sdi(sdi),
    .i_sdo(sdo), .i_sdo_oe(sdo_oe));

  // Clock of 200 MHz.
  always #2.5 i_clk = ~i_clk;

  // Background kicks keep the supervisor quiet while other behaviour is tested.
  always begin
    repeat (40) @(negedge i_clk);
    if (kick_run) kick = ~kick;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check

  task automatic cyc(input int k);
    repeat (k) @(negedge i_clk);
  endtask : cyc

  // One full frame; the command lands at the close, the status is returned in rd.
  task automatic frame(input logic [15:0] word);
    u_swmon_host_model.shift(word, 16, rd, oe_ok);
    u_swmon_host_model.close();
    cyc(1);
  endtask : frame

  task automatic report_and_stop;
    $display("checked %0d, mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : report_and_stop

  // Hang guard, well above the expected run of under a thousand cycles.
  initial begin
    #60000;
    mismatches++;
    report_and_stop();
  end

  initial begin
    {i_clk, kick, uv, sw, kick_run} = '0;
    {sd_n, on_n, hold_n, i_reset} = 4'hf;
    mismatches = 0;
    checked = 0;
    cyc(3);
    i_reset = 1'b0;
    cyc(1);
    check(16'(sense), 16'h00fc);
    check(16'({alert_oe, sdo_oe, srst_oe}), 16'h0000);
    check(16'({alert, srst}), 16'h0000);
    // Regulator control table, shutdown rows last so ready starts from low.
    foreach (rows[i]) begin
      {sd_n, on_n, hold_n} = rows[i][3:1];
      cyc(6);
      check(16'(reg_en), 16'(rows[i][0]));
      if (!sd_n) check(16'(sense), 16'h0000);
    end
    kick_run = 1'b1;
    {sd_n, on_n, hold_n} = 3'b111;
    for (n = 0; n < 20 && reg_en !== 1'b1; n++) cyc(1);
    cyc(REG - 3);
    check(16'(reg_rdy), 16'h0000);
    cyc(6);
    check(16'(reg_rdy), 16'h0001);
    // Direct copies of inputs 0 and 1.
    for (int v = 1; v < 4; v++) begin
      sw = 8'(v);
      cyc(6);
      check(16'({do1, do0}), 16'(v));
    end
    sw = 8'h10;
    cyc(DEB + 8);
    check(16'(alert_oe), 16'h0001);
    frame(16'h0000);
    check(rd, 16'h0110);
    check(16'({alert_oe, sdo_oe, oe_ok}), 16'h0001);
    // Command not taken until select rises.
    u_swmon_host_model.shift(16'h0120, 16, rd, oe_ok);
    check(16'(sense), 16'h00fc);
    u_swmon_host_model.close();
    cyc(1);
    check(16'(sense), 16'h00ff);
    u_swmon_host_model.shift(16'h0000, 15, rd, oe_ok);
    u_swmon_host_model.close();
    cyc(1);
    check(16'(sense), 16'h00ff);
    sw = 8'h30;
    cyc(DEB + 8);
    check(16'(alert_oe), 16'h0000);
    // Staggered changes restart the one shared timer.
    sw = 8'h70;
    cyc(10);
    sw = 8'hf0;
    cyc(DEB - 5);
    check(16'(alert_oe), 16'h0000);
    cyc(12);
    check(16'(alert_oe), 16'h0001);
    frame(16'h0320);
    cyc(SPER);
    n = 0;
    repeat (SPER) begin
      cyc(1);
      if (sense !== 8'h00) n++;
    end
    check(16'(n), 16'(SON));
    frame(16'h0120);
    // Supervisor: stop kicking just after one last edge.
    kick_run = 1'b0;
    cyc(1);
    kick = ~kick;
    cyc(WD1 - 4);
    check(16'({alert_oe, srst_oe}), 16'h0000);
    cyc(10);
    check(16'(alert_oe), 16'h0001);
    cyc(WD2 - WD1 - 10);
    check(16'(srst_oe), 16'h0000);
    cyc(10);
    check(16'(srst_oe), 16'h0001);
    cyc(RST + 4);
    check(16'({alert_oe, srst_oe}), 16'h0000);
    kick_run = 1'b1;
    uv = 1'b1;
    cyc(6);
    check(16'(srst_oe), 16'h0001);
    uv = 1'b0;
    cyc(6);
    check(16'(srst_oe), 16'h0000);
    // Host lets go of the hold line, then a switch change wakes the regulator again.
    {sd_n, on_n, hold_n} = 3'b110;
    cyc(6);
    check(16'(reg_en), 16'h0000);
    sw = 8'h70;
    cyc(DEB + 8);
    on_n = ~alert_oe;
    cyc(6);
    check(16'(reg_en), 16'h0001);
    report_and_stop();
  end
endmodule : switch_monitor_control_port_tb_top
